// ---- rtl/codec_init_power_sequencer.sv ----
// Start-up, mode select and power-down sequencer for the codec.
// Assumes register strobes from control-port logic on i_clk_sys; pins are asynchronous.
`timescale 1ns/1ps
`include "codec_init_defs.svh"
module codec_init_power_sequencer
  import codec_init_pkg::*;
#(
  parameter int RATIO_W      = 12,
  parameter int RAMP_SAMPLES = `RAMP_SAMPLE_COUNT,
  parameter int MCLK_TIMEOUT = `MCLK_TIMEOUT_CYCLES,
  parameter int MUTE_CYCLES  = `MUTE_SETTLE_CYCLES
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset,
  input  wire logic               i_reset_pin_n,
  input  wire logic               i_serial_audio_out,
  input  wire logic               i_master_clock_primary,
  input  wire logic               i_frame_clock,
  input  wire logic               i_hw_mute,
  input  wire logic               i_clock_change,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [7:0]         i_reg_wdata,
  output logic [7:0]              o_reg_rdata,
  output logic                    o_power_enable,
  output logic                    o_logic_reset,
  output logic                    o_ramp_active,
  output mute_bundle_t            o_mute,
  output logic                    o_external_mute_ctrl_n,
  output logic                    o_normal_op,
  output logic                    o_hw_mode,
  output logic [RATIO_W-1:0]      o_clock_ratio
);

  logic [4:0]   sync1_ff;
  logic [4:0]   sync2_ff;
  logic [2:0]   prev_ff;
  logic         rst_lvl;
  logic         serial_audio_out_lvl;
  logic         hw_mute_lvl;
  logic         mclk_rise;
  logic         frame_rise;
  logic         rst_rise;
  seq_state_t   state_ff;
  seq_state_t   nxt_state;
  logic         hw_mode_ff;
  op_ctrl_t     op_ff;
  logic [15:0]  wait_cnt_ff;
  logic [15:0]  mclk_idle_ff;
  logic         mclk_valid;
  logic         ratio_done;
  logic         sw_pdn;
  logic         mute_cause;
  logic         reg_hit;

  // Two-stage synchronisers for all pins
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      prev_ff  <= 3'h0;
    end else begin
      sync1_ff <= {i_hw_mute, i_serial_audio_out, i_frame_clock, i_master_clock_primary, i_reset_pin_n};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff[2:0];
    end
  end

  assign rst_lvl     = sync2_ff[0];
  assign serial_audio_out_lvl   = sync2_ff[3];
  assign hw_mute_lvl = sync2_ff[4];
  assign rst_rise    = sync2_ff[0] & ~prev_ff[0];
  assign mclk_rise   = sync2_ff[1] & ~prev_ff[1];
  assign frame_rise  = sync2_ff[2] & ~prev_ff[2];
  assign sw_pdn      = ~hw_mode_ff & op_ff.power_down_bit;

  // Master clock presence watchdog
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mclk_idle_ff <= 16'(MCLK_TIMEOUT);
    end else if (mclk_rise) begin
      mclk_idle_ff <= 16'h0000;
    end else if (mclk_idle_ff != 16'(MCLK_TIMEOUT)) begin
      mclk_idle_ff <= mclk_idle_ff + 16'h0001;
    end
  end

  assign mclk_valid = (mclk_idle_ff != 16'(MCLK_TIMEOUT));

  // Mode capture at reset pin release
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      hw_mode_ff <= 1'b0;
    end else if (state_ff == ST_PDN && rst_rise) begin
      hw_mode_ff <= serial_audio_out_lvl;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_PDN: begin
        if (rst_rise) begin
          nxt_state = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (mclk_valid && (hw_mode_ff || !op_ff.power_down_bit)) begin
          nxt_state = ST_RAMP;
        end
      end
      ST_RAMP: begin
        if (sw_pdn) begin
          nxt_state = ST_MUTING;
        end else if (frame_rise && wait_cnt_ff == 16'(RAMP_SAMPLES - 1)) begin
          nxt_state = ST_MEASURE;
        end
      end
      ST_MEASURE: begin
        if (sw_pdn) begin
          nxt_state = ST_MUTING;
        end else if (ratio_done) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (sw_pdn) begin
          nxt_state = ST_MUTING;
        end
      end
      ST_MUTING: begin
        if (wait_cnt_ff == 16'(MUTE_CYCLES - 1)) begin
          nxt_state = ST_STANDBY;
        end
      end
      default: begin
        nxt_state = ST_PDN;
      end
    endcase
    if (!rst_lvl) begin
      nxt_state = ST_PDN;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      state_ff <= ST_PDN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Ramp sample counter and mute settle counter
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || state_ff != nxt_state) begin
      wait_cnt_ff <= 16'h0000;
    end else if ((state_ff == ST_RAMP && frame_rise) || state_ff == ST_MUTING) begin
      wait_cnt_ff <= wait_cnt_ff + 16'h0001;
    end
  end

  clock_ratio_counter #(
    .RATIO_W      (RATIO_W)
  ) u_ratio (
    .i_clk_sys    (i_clk_sys),
    .i_reset      (i_reset),
    .i_enable     (state_ff == ST_MEASURE),
    .i_mclk_rise  (mclk_rise),
    .i_frame_rise (frame_rise),
    .o_done       (ratio_done),
    .o_ratio      (o_clock_ratio)
  );

  // Operational control register
  assign reg_hit = (i_reg_addr == `OP_CTRL_OFFSET);

  always_ff @(posedge i_clk_sys) begin
    if (i_reset || state_ff == ST_PDN) begin
      op_ff <= op_ctrl_t'(`OP_CTRL_RESET);
    end else if (i_reg_wr && reg_hit && !hw_mode_ff) begin
      op_ff.power_down_bit <= i_reg_wdata[0];
      op_ff.soft_mute      <= i_reg_wdata[1];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd && reg_hit && !hw_mode_ff && state_ff != ST_PDN) begin
      o_reg_rdata <= {state_ff == ST_RUN, 5'h00, op_ff.soft_mute, op_ff.power_down_bit};
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

  assign mute_cause = (state_ff != ST_RUN) | ~rst_lvl | op_ff.soft_mute | hw_mute_lvl | sw_pdn;

  // Registered outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_power_enable         <= 1'b0;
      o_logic_reset          <= 1'b1;
      o_ramp_active          <= 1'b0;
      o_mute                 <= 3'b111;
      o_external_mute_ctrl_n <= 1'b0;
      o_normal_op            <= 1'b0;
      o_hw_mode              <= 1'b0;
    end else begin
      o_power_enable         <= (state_ff != ST_PDN) && (state_ff != ST_STANDBY);
      o_logic_reset          <= (state_ff == ST_PDN);
      o_ramp_active          <= (state_ff == ST_RAMP);
      o_mute.serial_audio_out <= (state_ff != ST_RUN);
      o_mute.line_out        <= (state_ff != ST_RUN) | op_ff.soft_mute | hw_mute_lvl;
      o_mute.dac_zero        <= (state_ff != ST_RUN) | i_clock_change;
      o_external_mute_ctrl_n <= ~mute_cause;
      o_normal_op            <= (state_ff == ST_RUN);
      o_hw_mode              <= hw_mode_ff;
    end
  end

  property p_pin_low_pdn;
    @(posedge i_clk_sys) disable iff (i_reset) !rst_lvl |=> state_ff == ST_PDN;
  endproperty
  a_pin_low_pdn: assert property (p_pin_low_pdn) else $error("Not powered down with reset pin low");

  property p_pdn_outputs;
    @(posedge i_clk_sys) disable iff (i_reset) state_ff == ST_PDN |=> o_logic_reset && !o_power_enable;
  endproperty
  a_pdn_outputs: assert property (p_pdn_outputs) else $error("Power-down outputs wrong");

  property p_mode_sample;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_ff == ST_PDN && rst_rise && rst_lvl) |=> hw_mode_ff == $past(serial_audio_out_lvl);
  endproperty
  a_mode_sample: assert property (p_mode_sample) else $error("Mode not taken from data-out level");

  property p_ramp_needs_mclk;
    @(posedge i_clk_sys) disable iff (i_reset) $rose(state_ff == ST_RAMP) |-> $past(mclk_valid);
  endproperty
  a_ramp_needs_mclk: assert property (p_ramp_needs_mclk) else $error("Ramp without master clock");

  property p_ramp_muted;
    @(posedge i_clk_sys) disable iff (i_reset)
      state_ff == ST_RAMP ##1 state_ff == ST_RAMP |-> o_mute.serial_audio_out && o_mute.line_out;
  endproperty
  a_ramp_muted: assert property (p_ramp_muted) else $error("Outputs not muted during ramp");

  property p_run_after_ratio;
    @(posedge i_clk_sys) disable iff (i_reset) $rose(state_ff == ST_RUN) |-> $past(ratio_done);
  endproperty
  a_run_after_ratio: assert property (p_run_after_ratio) else $error("Run entered without ratio");

  property p_sw_standby;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_ff == ST_STANDBY && !hw_mode_ff && op_ff.power_down_bit) |=> state_ff inside {ST_STANDBY, ST_PDN};
  endproperty
  a_sw_standby: assert property (p_sw_standby) else $error("Left standby with power-down bit set");

  property p_mute_before_off;
    @(posedge i_clk_sys) disable iff (i_reset)
      (state_ff == ST_RUN && sw_pdn && rst_lvl) |=> state_ff == ST_MUTING ##1 o_power_enable;
  endproperty
  a_mute_before_off: assert property (p_mute_before_off) else $error("Powered off before muting");

  property p_clock_change_zero;
    @(posedge i_clk_sys) disable iff (i_reset) i_clock_change |=> o_mute.dac_zero;
  endproperty
  a_clock_change_zero: assert property (p_clock_change_zero) else $error("DAC not zeroed in clock change");

  property p_ext_mute_low;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!o_normal_op || o_mute.line_out || o_logic_reset) |-> !o_external_mute_ctrl_n;
  endproperty
  a_ext_mute_low: assert property (p_ext_mute_low) else $error("External mute not driven low");

  property p_ext_mute_release;
    @(posedge i_clk_sys) disable iff (i_reset) $rose(o_external_mute_ctrl_n) |-> !$past(mute_cause) && o_normal_op;
  endproperty
  a_ext_mute_release: assert property (p_ext_mute_release) else $error("External mute released early");

  property p_ramp_length;
    @(posedge i_clk_sys) disable iff (i_reset)
      $rose(state_ff == ST_MEASURE) |-> $past(wait_cnt_ff) == 16'(RAMP_SAMPLES - 1);
  endproperty
  a_ramp_length: assert property (p_ramp_length) else $error("Ramp length wrong");

  property p_hw_no_write;
    @(posedge i_clk_sys) disable iff (i_reset) (hw_mode_ff && state_ff != ST_PDN) |=> $stable(op_ff);
  endproperty
  a_hw_no_write: assert property (p_hw_no_write) else $error("Register changed in hardware mode");

endmodule // codec_init_power_sequencer

// ---- rtl/codec_init_defs.svh ----
// Offsets, reset values and timing counts for the codec start-up sequencer.
// Assumes a 250 MHz system clock; included by bare name.
//
// Function
// - Power-on: filters, registers reset, analog off.
// - Stay powered down while reset pin low.
// - Reset release samples data-out: high hardware, low software.
// - Hardware mode ramps once master clock valid.
// - Mute data-out and line outputs while ramping.
// - Measure master clocks per frame, then run.
// - Software mode standby until power-down bit cleared.
// - Setting power-down bit completes muting before off.
// - DAC outputs zero data during clock change.
// - External mute asserted in every mute condition; code leaves it off for clock-change DAC zeroing.
// - External mute low means mute, high otherwise.
// - Registers writable only in software mode.
// - Audio starts after 2000 sample periods of ramp.
`ifndef CODEC_INIT_DEFS_SVH
`define CODEC_INIT_DEFS_SVH

`define OP_CTRL_OFFSET      8'h02
`define OP_CTRL_RESET       8'h01
`define RAMP_SAMPLE_COUNT   2000
`define CLK_PERIOD_NS       4
`define MCLK_TIMEOUT_NS     256
`define MCLK_TIMEOUT_CYCLES (`MCLK_TIMEOUT_NS / `CLK_PERIOD_NS)
`define MUTE_SETTLE_NS      4096
`define MUTE_SETTLE_CYCLES  (`MUTE_SETTLE_NS / `CLK_PERIOD_NS)

`endif

// ---- rtl/codec_init_pkg.sv ----
// Types shared by the codec start-up sequencer.
// Assumes nothing of its surroundings.
package codec_init_pkg;

  typedef enum logic [2:0] {
    ST_PDN     = 3'b000,
    ST_STANDBY = 3'b001,
    ST_RAMP    = 3'b010,
    ST_MEASURE = 3'b011,
    ST_RUN     = 3'b100,
    ST_MUTING  = 3'b101
  } seq_state_t;

  typedef struct packed {
    logic       running;
    logic [4:0] unused;
    logic       soft_mute;
    logic       power_down_bit;
  } op_ctrl_t;

  typedef struct packed {
    logic serial_audio_out;
    logic line_out;
    logic dac_zero;
  } mute_bundle_t;

endpackage

// ---- rtl/clock_ratio_counter.sv ----
// Counts master clock edges over one frame clock period.
// Assumes edge pulses already synchronised to the system clock.
`timescale 1ns/1ps
module clock_ratio_counter #(
  parameter int RATIO_W = 12
) (
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset,
  input  wire logic               i_enable,
  input  wire logic               i_mclk_rise,
  input  wire logic               i_frame_rise,
  output logic                    o_done,
  output logic [RATIO_W-1:0]      o_ratio
);

  logic               armed_ff;
  logic               counting_ff;
  logic [RATIO_W-1:0] cnt_ff;

  // Wait for a frame edge, count, stop at the next
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || !i_enable) begin
      armed_ff    <= 1'b0;
      counting_ff <= 1'b0;
      cnt_ff      <= '0;
      o_done      <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!armed_ff && i_frame_rise) begin
        armed_ff    <= 1'b1;
        counting_ff <= 1'b1;
        cnt_ff      <= '0;
      end else if (counting_ff && i_frame_rise) begin
        counting_ff <= 1'b0;
        o_done      <= 1'b1;
      end else if (counting_ff && i_mclk_rise) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_ratio <= '0;
    end else if (counting_ff && i_frame_rise) begin
      o_ratio <= cnt_ff;
    end
  end

endmodule // clock_ratio_counter

// ---- testbench/codec_host_model.sv ----
// Host-side pin model: master clock, frame clock and data-out strap.
// Assumes the bench gates the clocks and picks the strap level.
`timescale 1ns/1ps
module codec_host_model (
  input  wire logic i_mclk_en,
  input  wire logic i_frame_en,
  input  wire logic i_pull_high,
  output logic      o_master_clock_primary,
  output logic      o_frame_clock,
  output logic      o_serial_audio_out
);
  logic [5:0] tick_ff;
  logic       mclk_on;
  logic       frame_on;

  initial begin
    tick_ff  = 6'h00;
    mclk_on  = 1'b0;
    frame_on = 1'b0;
  end

  // Gates switch only while their clock is low: no runt edges
  always #8 begin
    tick_ff = tick_ff + 6'h01;
    if (!tick_ff[1]) begin
      mclk_on = i_mclk_en;
    end
    if (!tick_ff[5]) begin
      frame_on = i_frame_en;
    end
  end

  // Clocks stand low while gated off; frame edges only meet master falling edges
  assign o_master_clock_primary = mclk_on & tick_ff[1];
  assign o_frame_clock          = frame_on & tick_ff[5];
  // Strap resistor sets the line level
  assign o_serial_audio_out     = i_pull_high;
endmodule // codec_host_model

// ---- testbench/codec_init_power_sequencer_tb.sv ----
// Self-checking bench for the codec start-up sequencer.
// Assumes the host model drives clocks and strap; bench drives pins and registers.
`timescale 1ns/1ps
`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, act, exp); end end
module codec_init_power_sequencer_tb
  import codec_init_pkg::*;
;
  logic         clk, reset, pin_n, hw_mute, clk_change, reg_wr, reg_rd;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata;
  logic         power_en, logic_rst, ramp, ext_n, normal_op, hw_mode;
  mute_bundle_t mute;
  logic [11:0]  ratio;
  logic         mclk_en, frame_en, pull_high, mclk, frame, sdo;
  int           n_errors, checked, cycles;

  codec_host_model i_host (.i_mclk_en(mclk_en), .i_frame_en(frame_en), .i_pull_high(pull_high),
    .o_master_clock_primary(mclk), .o_frame_clock(frame), .o_serial_audio_out(sdo));

  codec_init_power_sequencer #(.RAMP_SAMPLES(4), .MUTE_CYCLES(8), .MCLK_TIMEOUT(64)) i_dut (
    .i_clk_sys(clk), .i_reset(reset), .i_reset_pin_n(pin_n), .i_serial_audio_out(sdo),
    .i_master_clock_primary(mclk), .i_frame_clock(frame), .i_hw_mute(hw_mute),
    .i_clock_change(clk_change), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_power_enable(power_en),
    .o_logic_reset(logic_rst), .o_ramp_active(ramp), .o_mute(mute),
    .o_external_mute_ctrl_n(ext_n), .o_normal_op(normal_op), .o_hw_mode(hw_mode),
    .o_clock_ratio(ratio));

  task automatic results();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    d = reg_rdata;
    reg_rd = 1'b0;
    cyc(1);
  endtask

  // Ramp with mutes held, then normal operation
  task automatic ramp_to_run();
    int k;
    k = 0;
    while (ramp !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    `CHK(power_en, 1'b1)
    `CHK(mute, 3'b111)
    `CHK(ext_n, 1'b0)
    k = 0;
    while (ramp === 1'b1 && k < 1000) begin
      cyc(1);
      k++;
    end
    `CHK(k >= 380 && k <= 560, 1'b1)
    k = 0;
    while (normal_op !== 1'b1 && k < 1000) begin
      cyc(1);
      k++;
    end
    `CHK(normal_op, 1'b1)
    cyc(2);
    `CHK(ratio, 12'h010)
  endtask

  task automatic t_powered_down();
    logic [7:0] d;
    cyc(20);
    `CHK(power_en, 1'b0)
    `CHK(logic_rst, 1'b1)
    `CHK(mute, 3'b111)
    `CHK(ext_n, 1'b0)
    wr(8'h02, 8'h00);
    rd(8'h02, d);
    `CHK(d, 8'h00)
    `CHK(power_en, 1'b0)
  endtask

  task automatic t_hw_start();
    logic [7:0] d;
    pull_high = 1'b1;
    mclk_en = 1'b1;
    cyc(10);
    pin_n = 1'b1;
    cyc(1);
    frame_en = 1'b1;
    ramp_to_run();
    `CHK(hw_mode, 1'b1)
    `CHK(ext_n, 1'b1)
    rd(8'h02, d);
    `CHK(d, 8'h00)
    wr(8'h02, 8'h03);
    `CHK(ext_n, 1'b1)
    `CHK(power_en, 1'b1)
    hw_mute = 1'b1;
    cyc(6);
    `CHK(ext_n, 1'b0)
    hw_mute = 1'b0;
    cyc(6);
    `CHK(ext_n, 1'b1)
    repeat (10) @(posedge frame);
    cyc(1);
    clk_change = 1'b1;
    cyc(3);
    `CHK(mute.dac_zero, 1'b1)
    clk_change = 1'b0;
    cyc(3);
    `CHK(mute.dac_zero, 1'b0)
    pin_n = 1'b0;
    cyc(6);
    `CHK(power_en, 1'b0)
    `CHK(ext_n, 1'b0)
    mclk_en = 1'b0;
    frame_en = 1'b0;
  endtask

  task automatic t_sw_start();
    logic [7:0] d;
    int k;
    pull_high = 1'b0;
    cyc(4);
    pin_n = 1'b1;
    cyc(10);
    `CHK(hw_mode, 1'b0)
    rd(8'h02, d);
    `CHK(d, 8'h01)
    wr(8'h02, 8'h03);
    rd(8'h02, d);
    `CHK(d, 8'h03)
    rd(8'h05, d);
    `CHK(d, 8'h00)
    mclk_en = 1'b1;
    cyc(50);
    `CHK(power_en, 1'b0)
    wr(8'h02, 8'h02);
    frame_en = 1'b1;
    ramp_to_run();
    rd(8'h02, d);
    `CHK(d, 8'h82)
    `CHK(ext_n, 1'b0)
    wr(8'h02, 8'h00);
    cyc(2);
    `CHK(ext_n, 1'b1)
    wr(8'h02, 8'h02);
    `CHK(ext_n, 1'b0)
    wr(8'h02, 8'h03);
    `CHK(power_en, 1'b1)
    `CHK(ext_n, 1'b0)
    k = 0;
    while (power_en !== 1'b0 && k < 100) begin
      cyc(1);
      k++;
    end
    `CHK(k >= 5 && k <= 20, 1'b1)
    `CHK(mute, 3'b111)
    pin_n = 1'b0;
    cyc(6);
    `CHK(logic_rst, 1'b1)
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    n_errors = 0;
    checked = 0;
    cycles = 0;
    reset = 1'b1;
    pin_n = 1'b0;
    hw_mute = 1'b0;
    clk_change = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    mclk_en = 1'b0;
    frame_en = 1'b0;
    pull_high = 1'b0;
    cyc(3);
    reset = 1'b0;
    t_powered_down();
    t_hw_start();
    t_sw_start();
    results();
  end
endmodule // codec_init_power_sequencer_tb
